/* rtl/crsg_map.svh */
`ifndef CRSG_MAP_SVH
`define CRSG_MAP_SVH
// Contract
// - power ok high only inside window
// - window 300 mV below, 200 mV above
// - dac under 300 mV: upper limit only
// - mask power ok failures 130 us
// - large drop in sleep moves lengthen mask (code: only during slow entry and slow exit, not fast exit)
// - soft start node zero when off
// - supply and enable start 50-60 us reset
// - detect phase count, then start ramp
// - ramp charged at 8 uA to boot
// - boot level from built-in code
// - ramp at 1.7 V drops clock permit (code also waits for the rail inside the window)
// - sample cpu code, soft move to it
// - boot to code uses 48 uA to clamp
// - delay node discharged before clock permit
// - delay charged 2 uA, power ok at 2.9 V
// - enable or supply loss discharges both nodes
// - soft transition for sleep moves and boot
// - reference from slew buffer during transition
// - slew current chosen by transition type
// - two phases take alternate ramp cycles
// - every code change restarts mask timer (code: only code changes in boot and run states)
// - ignore new code for 400 ns

// register byte offsets
`define CRSG_REG_CTRL       12'h000
`define CRSG_REG_STATUS     12'h004
`define CRSG_REG_CODE       12'h008
// control fields and reset value
`define CRSG_CTRL_EN_BIT     0
`define CRSG_CTRL_SINGLE_BIT 1
`define CRSG_CTRL_RST        2'h1
// status fields
`define CRSG_ST_STATE_LSB    0
`define CRSG_ST_POK_BIT      3
`define CRSG_ST_CLKP_BIT     4
`define CRSG_ST_MASK_BIT     5
`define CRSG_ST_TWOPH_BIT    6
`define CRSG_ST_DACLOW_BIT   7
`define CRSG_ST_SLEW_BIT     8
// timing
`define CRSG_CLK_KHZ        25000
`define CRSG_RESET_US       50
`define CRSG_MASK_US        130
`define CRSG_SKEW_NS        400
`define CRSG_RESET_CYC ((`CRSG_RESET_US * `CRSG_CLK_KHZ + 999) / 1000)
`define CRSG_MASK_CYC  ((`CRSG_MASK_US * `CRSG_CLK_KHZ) / 1000)
`define CRSG_SKEW_CYC  ((`CRSG_SKEW_NS * `CRSG_CLK_KHZ + 999999) / 1000000)
`endif

/* rtl/crsg_pkg.sv */
package crsg_pkg;
  typedef enum logic [2:0] {
    ST_OFF, ST_RESET, ST_PHASE, ST_SOFT, ST_BOOT, ST_RUN
  } crsg_state_e;

  typedef enum logic [2:0] {
    SLEW_NONE, SLEW_SLOW_ENTRY, SLEW_FAST_EXIT, SLEW_SLOW_EXIT, SLEW_BOOT
  } crsg_slew_e;

  // comparator and strap results from the analog side
  typedef struct packed {
    logic supply_ok;       // supply above upper lockout level
    logic enable;          // enable pin
    logic ss_at_start;     // ramp node at 1.7 V
    logic ss_at_clamp;     // ramp node at 2.9 V clamp
    logic delay_at_term;   // good delay node at 2.9 V
    logic below_upper;     // core rail under dac + 200 mV
    logic above_lower;     // core rail over dac - 300 mV
    logic drop_large;      // core rail drop over 200 mV
    logic two_phase_sel;   // user phase count strap
    logic ramp_cycle;      // internal ramp restart
  } crsg_cmp_s;

  // processor side inputs
  typedef struct packed {
    logic       deep_sleep_request;
    logic       deep_stop_request;
    logic [6:0] voltage_select_code;
  } crsg_cpu_s;

  // controls to the analog side
  typedef struct packed {
    logic       ss_discharge;
    logic       ss_charge_low;     // 8 uA source
    logic       ss_charge_high;    // 48 uA source
    logic       delay_discharge;
    logic       delay_charge;      // 2 uA source
    logic       ref_from_slew;     // amplifier reference on slew node
    crsg_slew_e slew_sel;          // slew node current
  } crsg_ana_s;
endpackage : crsg_pkg

/* rtl/crsg_sequencer.sv */
`timescale 1ns/1ps
`include "crsg_map.svh"
module crsg_sequencer #(
  parameter int unsigned RESET_CYC = `CRSG_RESET_CYC,
  parameter int unsigned MASK_CYC  = `CRSG_MASK_CYC,
  parameter int unsigned SKEW_CYC  = `CRSG_SKEW_CYC,
  parameter logic [6:0]  BOOT_CODE = 7'h00,  // built-in start code
  parameter logic [6:0]  LOW_CODE  = 7'h60   // first code under 300 mV
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 ce_i,
  input  wire crsg_pkg::crsg_cmp_s  cmp_i,
  input  wire crsg_pkg::crsg_cpu_s  cpu_i,
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [11:0]          paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic [31:0]               prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  output crsg_pkg::crsg_ana_s       ana_o,
  output logic [6:0]                dac_code_o,
  output logic                      power_ok_output_o,
  output logic                      cpu_clock_permit_o,
  output logic                      phase_sel_o
);
  localparam int unsigned CW = 12;

  // elaboration checks on counter capacity
  if (RESET_CYC < 1 || RESET_CYC >= (1 << CW)) begin : g_chk_rst
    $error("reset cycle count out of range");
  end
  if (MASK_CYC < 1 || MASK_CYC >= (1 << CW)) begin : g_chk_mask
    $error("mask count out of range");
  end
  if (SKEW_CYC < 1 || SKEW_CYC >= (1 << CW) - 1) begin : g_chk_skew
    $error("skew count out of range");
  end

  localparam logic [CW-1:0] RESET_LAST = CW'(RESET_CYC - 1);
  localparam logic [CW-1:0] MASK_LOAD  = CW'(MASK_CYC);
  localparam logic [CW-1:0] SKEW_LOAD  = CW'(SKEW_CYC);

  // dac code at or past LOW_CODE gives under 300 mV
  function automatic logic dac_low(input logic [6:0] code);
    dac_low = (code >= LOW_CODE);
  endfunction : dac_low

  crsg_pkg::crsg_cmp_s   cmp;
  crsg_pkg::crsg_cpu_s   cpu;
  logic [18:0]           sync_q;
  crsg_pkg::crsg_state_e st_r;
  crsg_pkg::crsg_slew_e  slew_r;
  logic [CW-1:0]         seq_cnt_r;
  logic [CW-1:0]         mask_cnt_r;
  logic [CW-1:0]         skew_cnt_r;
  logic [6:0]            dac_code_r;
  logic [6:0]            seen_code_r;
  logic                  two_phase_r;
  logic                  clk_permit_r;
  logic                  pok_r;
  logic                  phase_r;
  logic                  ramp_d_r;
  logic                  sleep_d_r;
  logic                  stop_d_r;
  logic [1:0]            ctrl_r;
  logic                  pready_r;
  logic                  pslverr_r;
  logic [31:0]           prdata_r;
  logic                  power_up;
  logic                  window_ok;
  logic                  mask_act;
  logic                  code_evt;
  logic                  boot_go;
  logic                  sleep_entry;
  logic                  fast_exit;
  logic                  slow_exit;
  logic                  sleep_evt;
  logic                  extend;
  logic                  apb_setup;
  logic                  apb_write;

  // comparators, strap and cpu pins enter through one synchroniser
  crsg_sync #(
    .WIDTH (19)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .ce_i       (ce_i),
    .async_i    ({cmp_i, cpu_i}),
    .sync_o     (sync_q)
  );

  assign cmp = crsg_pkg::crsg_cmp_s'(sync_q[18:9]);
  assign cpu = crsg_pkg::crsg_cpu_s'(sync_q[8:0]);

  // start conditions and window evaluation
  assign power_up  = cmp.supply_ok & cmp.enable
                   & ctrl_r[`CRSG_CTRL_EN_BIT];
  assign window_ok = cmp.below_upper
                   & (cmp.above_lower | dac_low(dac_code_r));
  assign mask_act  = (mask_cnt_r != '0);
  assign boot_go   = (st_r == crsg_pkg::ST_SOFT) & cmp.ss_at_start
                   & window_ok;
  assign code_evt  = (skew_cnt_r == CW'(1));

  // sleep transitions, only once the rail is on its coded level
  assign sleep_entry = cpu.deep_sleep_request & ~sleep_d_r;
  assign fast_exit   = ~cpu.deep_sleep_request & sleep_d_r;
  assign slow_exit   = cpu.deep_sleep_request & cpu.deep_stop_request
                     & ~stop_d_r;
  assign sleep_evt   = (st_r == crsg_pkg::ST_RUN)
                     & (sleep_entry | fast_exit | slow_exit);
  assign extend      = mask_act & cmp.drop_large
                     & ((slew_r == crsg_pkg::SLEW_SLOW_ENTRY)
                     |  (slew_r == crsg_pkg::SLEW_SLOW_EXIT));

  // start-up sequence; loss of enable or supply returns to off
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_r      <= crsg_pkg::ST_OFF;
      seq_cnt_r <= '0;
    end else if (ce_i) begin
      if (!power_up) begin
        st_r      <= crsg_pkg::ST_OFF;
        seq_cnt_r <= '0;
      end else begin
        case (st_r)
          crsg_pkg::ST_OFF: begin
            st_r      <= crsg_pkg::ST_RESET;
            seq_cnt_r <= '0;
          end
          crsg_pkg::ST_RESET: begin
            if (seq_cnt_r == RESET_LAST) begin
              st_r <= crsg_pkg::ST_PHASE;
            end else begin
              seq_cnt_r <= seq_cnt_r + CW'(1);
            end
          end
          crsg_pkg::ST_PHASE: begin
            st_r <= crsg_pkg::ST_SOFT;
          end
          crsg_pkg::ST_SOFT: begin
            if (boot_go) begin
              st_r <= crsg_pkg::ST_BOOT;
            end
          end
          crsg_pkg::ST_BOOT: begin
            if (cmp.ss_at_clamp && !mask_act) begin
              st_r <= crsg_pkg::ST_RUN;
            end
          end
          crsg_pkg::ST_RUN: begin
            st_r <= crsg_pkg::ST_RUN;
          end
          default: begin
            st_r <= crsg_pkg::ST_OFF;
          end
        endcase
      end
    end
  end

  // phase count taken once after the reset cycle
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      two_phase_r <= 1'b0;
    end else if (ce_i && st_r == crsg_pkg::ST_PHASE) begin
      two_phase_r <= cmp.two_phase_sel
                   & ~ctrl_r[`CRSG_CTRL_SINGLE_BIT];
    end
  end

  // code change filter: a new code waits out the skew time
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      seen_code_r <= 7'h00;
      skew_cnt_r  <= '0;
    end else if (ce_i) begin
      if (cpu.voltage_select_code != seen_code_r) begin
        seen_code_r <= cpu.voltage_select_code;
        skew_cnt_r  <= SKEW_LOAD + CW'(1);
      end else if (skew_cnt_r != '0) begin
        skew_cnt_r <= skew_cnt_r - CW'(1);
      end
    end
  end

  // dac code: boot level until the hand-over, then the cpu code
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      dac_code_r <= BOOT_CODE;
    end else if (ce_i) begin
      case (st_r)
        crsg_pkg::ST_BOOT, crsg_pkg::ST_RUN: begin
          if (code_evt) begin
            dac_code_r <= seen_code_r;
          end
        end
        crsg_pkg::ST_SOFT: begin
          if (boot_go) begin
            dac_code_r <= seen_code_r;
          end else begin
            dac_code_r <= BOOT_CODE;
          end
        end
        default: begin
          dac_code_r <= BOOT_CODE;
        end
      endcase
    end
  end

  // mask timer; restarted by every code step in boot or run and every sleep move
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      mask_cnt_r <= '0;
    end else if (ce_i) begin
      if (!power_up) begin
        mask_cnt_r <= '0;
      end else if (boot_go || sleep_evt || extend) begin
        mask_cnt_r <= MASK_LOAD;
      end else if (code_evt && (st_r == crsg_pkg::ST_BOOT
                             || st_r == crsg_pkg::ST_RUN)) begin
        mask_cnt_r <= MASK_LOAD;
      end else if (mask_act) begin
        mask_cnt_r <= mask_cnt_r - CW'(1);
      end
    end
  end

  // transition type selects slew current for the masked period
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      slew_r <= crsg_pkg::SLEW_NONE;
    end else if (ce_i) begin
      if (!power_up) begin
        slew_r <= crsg_pkg::SLEW_NONE;
      end else if (boot_go) begin
        slew_r <= crsg_pkg::SLEW_BOOT;
      end else if (sleep_evt && sleep_entry) begin
        slew_r <= crsg_pkg::SLEW_SLOW_ENTRY;
      end else if (sleep_evt && fast_exit) begin
        slew_r <= crsg_pkg::SLEW_FAST_EXIT;
      end else if (sleep_evt && slow_exit) begin
        slew_r <= crsg_pkg::SLEW_SLOW_EXIT;
      end else if (mask_cnt_r == CW'(1)) begin
        slew_r <= crsg_pkg::SLEW_NONE;
      end
    end
  end

  // previous levels for edge detection
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sleep_d_r <= 1'b0;
      stop_d_r  <= 1'b0;
      ramp_d_r  <= 1'b0;
    end else if (ce_i) begin
      sleep_d_r <= cpu.deep_sleep_request;
      stop_d_r  <= cpu.deep_stop_request;
      ramp_d_r  <= cmp.ramp_cycle;
    end
  end

  // clock permit: high until the ramp reaches its start level with the rail inside the window
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      clk_permit_r <= 1'b1;
    end else if (ce_i) begin
      if (!power_up) begin
        clk_permit_r <= 1'b1;
      end else if (boot_go) begin
        clk_permit_r <= 1'b0;
      end
    end
  end

  // power ok after the delay node ends, masked failures ignored
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pok_r <= 1'b0;
    end else if (ce_i) begin
      pok_r <= power_up && !clk_permit_r
            && cmp.delay_at_term
            && (window_ok || (mask_act && pok_r));
    end
  end

  // alternate ramp cycles serve phase one and phase two
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      phase_r <= 1'b0;
    end else if (ce_i) begin
      if (!two_phase_r || st_r == crsg_pkg::ST_OFF) begin
        phase_r <= 1'b0;
      end else if (cmp.ramp_cycle && !ramp_d_r) begin
        phase_r <= ~phase_r;
      end
    end
  end

  // analog node controls
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ana_o <= '{ss_discharge: 1'b1, delay_discharge: 1'b1,
                 slew_sel: crsg_pkg::SLEW_NONE, default: 1'b0};
    end else if (ce_i) begin
      ana_o.ss_discharge    <= (st_r == crsg_pkg::ST_OFF)
                            || (st_r == crsg_pkg::ST_RESET)
                            || (st_r == crsg_pkg::ST_PHASE);
      ana_o.ss_charge_low   <= (st_r == crsg_pkg::ST_SOFT);
      ana_o.ss_charge_high  <= (st_r == crsg_pkg::ST_BOOT)
                            || (st_r == crsg_pkg::ST_RUN);
      ana_o.delay_discharge <= clk_permit_r;
      ana_o.delay_charge    <= ~clk_permit_r;
      ana_o.ref_from_slew   <= (slew_r != crsg_pkg::SLEW_NONE);
      ana_o.slew_sel        <= slew_r;
    end
  end

  // pin outputs
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      dac_code_o         <= BOOT_CODE;
      power_ok_output_o  <= 1'b0;
      cpu_clock_permit_o <= 1'b1;
      phase_sel_o        <= 1'b0;
    end else if (ce_i) begin
      dac_code_o         <= dac_code_r;
      power_ok_output_o  <= pok_r;
      cpu_clock_permit_o <= clk_permit_r;
      phase_sel_o        <= phase_r;
    end
  end

  // apb slave: answer prepared in setup, ready in the access cycle
  assign apb_setup = psel_i & ~penable_i;
  assign apb_write = psel_i & penable_i & pready_r & pwrite_i & ~pslverr_r;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (ce_i) begin
      pready_r  <= apb_setup;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      if (apb_setup) begin
        case (paddr_i)
          `CRSG_REG_CTRL: begin
            prdata_r <= {30'h0, ctrl_r};
          end
          `CRSG_REG_STATUS: begin
            prdata_r[`CRSG_ST_STATE_LSB +: 3] <= st_r;
            prdata_r[`CRSG_ST_POK_BIT]        <= pok_r;
            prdata_r[`CRSG_ST_CLKP_BIT]       <= clk_permit_r;
            prdata_r[`CRSG_ST_MASK_BIT]       <= mask_act;
            prdata_r[`CRSG_ST_TWOPH_BIT]      <= two_phase_r;
            prdata_r[`CRSG_ST_DACLOW_BIT]     <= dac_low(dac_code_r);
            prdata_r[`CRSG_ST_SLEW_BIT]       <=
              (slew_r != crsg_pkg::SLEW_NONE);
          end
          `CRSG_REG_CODE: begin
            prdata_r <= {17'h0, seen_code_r, 1'b0, dac_code_r};
          end
          default: begin
            pslverr_r <= 1'b1;
          end
        endcase
      end
    end
  end

  // control register: enable and forced single phase
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ctrl_r <= `CRSG_CTRL_RST;
    end else if (ce_i && apb_write && paddr_i == `CRSG_REG_CTRL) begin
      ctrl_r <= pwdata_i[1:0];
    end
  end

  assign prdata_o  = prdata_r;
  assign pready_o  = pready_r;
  assign pslverr_o = pslverr_r;
endmodule : crsg_sequencer

/* rtl/crsg_sync.sv */
`timescale 1ns/1ps
// three stage synchroniser; a change is taken once stages two and three agree
module crsg_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             core_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  // capture chain
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else if (ce_i) begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // per bit agreement filter
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sync_o <= '0;
    end else if (ce_i) begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          sync_o[i] <= s3_r[i];
        end
      end
    end
  end
endmodule : crsg_sync

/* sim/crsg_cpu_model.sv */
`timescale 1ns/1ps
// processor side: shows its code, then walks it one lsb per step
module crsg_cpu_model #(
  parameter int unsigned STEP_CYC = 8
) (
  input  wire logic           core_clk_i,
  input  wire logic           clock_permit_i,
  input  wire logic [6:0]     target_i,
  input  wire logic           sleep_i,
  input  wire logic           stop_i,
  output crsg_pkg::crsg_cpu_s cpu_o
);
  int unsigned cnt = 0;

  initial cpu_o = '0;

  // steps are spaced well beyond the skew hold-off of the device
  always @(posedge core_clk_i) begin
    cnt <= (cnt + 1) % STEP_CYC;
    cpu_o.deep_sleep_request <= sleep_i;
    cpu_o.deep_stop_request  <= stop_i;
    if (clock_permit_i) begin
      cpu_o.voltage_select_code <= target_i;
    end else if (cnt == 0 && cpu_o.voltage_select_code < target_i) begin
      cpu_o.voltage_select_code <= cpu_o.voltage_select_code + 7'h01;
    end else if (cnt == 0 && cpu_o.voltage_select_code > target_i) begin
      cpu_o.voltage_select_code <= cpu_o.voltage_select_code - 7'h01;
    end
  end
endmodule : crsg_cpu_model

/* sim/crsg_sequencer_assertions.sv */
`timescale 1ns/1ps
module crsg_sequencer_assertions (
  input wire logic                core_clk_i,
  input wire logic                sys_rst_i,
  input wire crsg_pkg::crsg_cmp_s cmp_i,
  input wire logic                psel_i,
  input wire logic                penable_i,
  input wire logic [11:0]         paddr_i,
  input wire logic                pready_o,
  input wire logic                pslverr_o,
  input wire crsg_pkg::crsg_ana_s ana_o,
  input wire logic                power_ok_output_o,
  input wire logic                cpu_clock_permit_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  // clocks just permitted: boot-to-code move begins
  sequence s_boot_go;
    $fell(cpu_clock_permit_o);
  endsequence
  // supply or enable gone long enough to pass the synchroniser
  sequence s_power_lost;
    (!(cmp_i.supply_ok && cmp_i.enable)) [*8];
  endsequence

  a_apb_ready: assert property (psel_i && !penable_i |=> pready_o)
    else $error("ready missing in access cycle");
  a_apb_error: assert property (
    pready_o |-> pslverr_o != (paddr_i inside {12'h000, 12'h004, 12'h008}))
    else $error("error response does not match address");
  a_pok_permit: assert property (
    power_ok_output_o |-> !$past(cpu_clock_permit_o))
    else $error("power ok while clocks still held");
  a_pok_delay: assert property (
    (!cmp_i.delay_at_term) [*8] |-> !power_ok_output_o)
    else $error("power ok before delay node terminated");
  a_delay_held: assert property (
    cpu_clock_permit_o && $past(cpu_clock_permit_o)
      |-> ana_o.delay_discharge && !ana_o.delay_charge)
    else $error("delay node not held while clocks held");
  a_ss_exclusive: assert property (
    ana_o.ss_discharge |-> !(ana_o.ss_charge_low || ana_o.ss_charge_high))
    else $error("ramp node charged while discharged");
  a_ref_slew: assert property (
    ana_o.ref_from_slew == (ana_o.slew_sel != crsg_pkg::SLEW_NONE))
    else $error("reference select disagrees with slew state");
  a_boot_move: assert property (
    s_boot_go |-> ##[1:2] (ana_o.slew_sel == crsg_pkg::SLEW_BOOT
      && ana_o.ss_charge_high && ana_o.delay_charge))
    else $error("boot move controls missing");
  a_power_off: assert property (
    s_power_lost |-> cpu_clock_permit_o && !power_ok_output_o
      && ana_o.ss_discharge && ana_o.delay_discharge)
    else $error("nodes not discharged after power loss");
endmodule : crsg_sequencer_assertions

bind crsg_sequencer crsg_sequencer_assertions u_chk (
  .core_clk_i        (core_clk_i),
  .sys_rst_i         (sys_rst_i),
  .cmp_i             (cmp_i),
  .psel_i            (psel_i),
  .penable_i         (penable_i),
  .paddr_i           (paddr_i),
  .pready_o          (pready_o),
  .pslverr_o         (pslverr_o),
  .ana_o             (ana_o),
  .power_ok_output_o (power_ok_output_o),
  .cpu_clock_permit_o(cpu_clock_permit_o)
);

/* sim/crsg_sequencer_tb.sv */
`timescale 1ns/1ps
module crsg_sequencer_tb;
  localparam int unsigned RST_C = 8;
  localparam int unsigned MSK_C = 40;
  logic                 core_clk_i = 1'b0;
  logic                 sys_rst_i  = 1'b1;
  crsg_pkg::crsg_cmp_s  cmp        = '0;
  crsg_pkg::crsg_cpu_s  cpu;
  crsg_pkg::crsg_ana_s  ana;
  logic                 psel       = 1'b0;
  logic                 penable    = 1'b0;
  logic                 pwrite     = 1'b0;
  logic [11:0]          paddr      = '0;
  logic [31:0]          pwdata     = '0;
  logic [31:0]          prdata;
  logic [31:0]          rd;
  logic [6:0]           dac;
  logic [6:0]           target     = 7'h5E;
  logic                 sleep      = 1'b0;
  logic                 stop       = 1'b0;
  logic                 pready, pslverr, pok, permit, phase, err;
  int                   n_mismatch = 0;
  int                   n_compared = 0;
  int                   cyc        = 0;
  int                   n;
  logic [1:0]           sq [4]     = '{2'b10, 2'b00, 2'b10, 2'b11};
  crsg_pkg::crsg_slew_e ex [4]     = '{crsg_pkg::SLEW_SLOW_ENTRY,
    crsg_pkg::SLEW_FAST_EXIT, crsg_pkg::SLEW_SLOW_ENTRY,
    crsg_pkg::SLEW_SLOW_EXIT};

  // core clock
  initial forever #20 core_clk_i = ~core_clk_i;

  crsg_sequencer #(
    .RESET_CYC(RST_C),
    .MASK_CYC (MSK_C),
    .SKEW_CYC (2)
  ) u_dut (
    .core_clk_i        (core_clk_i),
    .sys_rst_i         (sys_rst_i),
    .ce_i              (1'b1),
    .cmp_i             (cmp),
    .cpu_i             (cpu),
    .psel_i            (psel),
    .penable_i         (penable),
    .pwrite_i          (pwrite),
    .paddr_i           (paddr),
    .pwdata_i          (pwdata),
    .prdata_o          (prdata),
    .pready_o          (pready),
    .pslverr_o         (pslverr),
    .ana_o             (ana),
    .dac_code_o        (dac),
    .power_ok_output_o (pok),
    .cpu_clock_permit_o(permit),
    .phase_sel_o       (phase)
  );

  crsg_cpu_model u_cpu (
    .core_clk_i    (core_clk_i),
    .clock_permit_i(permit),
    .target_i      (target),
    .sleep_i       (sleep),
    .stop_i        (stop),
    .cpu_o         (cpu)
  );

  task automatic tick(input int c);
    repeat (c) @(posedge core_clk_i);
  endtask : tick

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, idle cycle after it
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    tick(1);
    penable <= 1'b1;
    tick(1);
    while (pready !== 1'b1) tick(1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    tick(1);
  endtask : apb

  task automatic wait_dac(input logic [6:0] c);
    for (int k = 0; k < 300 && dac !== c; k++) tick(1);
    chk(dac, c);
  endtask : wait_dac

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // hang guard
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // test sequence
  initial begin
    tick(4);
    sys_rst_i <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd[6:0], 7'h00);
    apb(1'b0, 12'h010, 32'h0);
    chk(err, 1'b1);
    $display("test registers done");
    cmp.two_phase_sel <= 1'b1;
    cmp.above_lower   <= 1'b1;
    cmp.supply_ok     <= 1'b1;
    cmp.enable        <= 1'b1;
    for (n = 0; n < 200 && ana.ss_charge_low !== 1'b1; n++) tick(1);
    chk(n >= RST_C && n <= RST_C + 12, 1'b1);
    chk(permit, 1'b1);
    cmp.ss_at_start <= 1'b1;
    tick(12);
    chk(permit, 1'b1);
    chk(dac, 7'h00);
    cmp.below_upper <= 1'b1;
    tick(10);
    chk(permit, 1'b0);
    chk(ana.ss_charge_high, 1'b1);
    chk(ana.delay_charge, 1'b1);
    chk(ana.slew_sel, crsg_pkg::SLEW_BOOT);
    chk(pok, 1'b0);
    wait_dac(7'h5E);
    cmp.ss_at_clamp   <= 1'b1;
    cmp.delay_at_term <= 1'b1;
    tick(MSK_C + 10);
    chk(pok, 1'b1);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0000_004D);
    $display("test start-up done");
    target <= 7'h60;
    wait_dac(7'h60);
    cmp.above_lower <= 1'b0;
    tick(MSK_C + 10);
    chk(pok, 1'b1);
    target <= 7'h5B;
    wait_dac(7'h5B);
    tick(MSK_C - 12);
    chk(pok, 1'b1);
    tick(25);
    chk(pok, 1'b0);
    cmp.above_lower <= 1'b1;
    tick(10);
    chk(pok, 1'b1);
    cmp.below_upper <= 1'b0;
    tick(10);
    chk(pok, 1'b0);
    cmp.below_upper <= 1'b1;
    tick(10);
    $display("test window done");
    for (int i = 0; i < 4; i++) begin
      sleep <= sq[i][1];
      stop  <= sq[i][0];
      tick(14);
      chk(ana.slew_sel, ex[i]);
      chk(ana.ref_from_slew, 1'b1);
      if (i == 0) begin
        cmp.drop_large <= 1'b1;
        tick(MSK_C);
        chk(ana.slew_sel, ex[0]);
        cmp.drop_large <= 1'b0;
      end
      tick(MSK_C + 8);
      chk(ana.slew_sel, crsg_pkg::SLEW_NONE);
    end
    $display("test sleep done");
    for (int i = 0; i < 2; i++) begin
      cmp.ramp_cycle <= 1'b1;
      tick(6);
      cmp.ramp_cycle <= 1'b0;
      tick(6);
      chk(phase, i == 0);
    end
    $display("test phase done");
    cmp.enable        <= 1'b0;
    cmp.ss_at_start   <= 1'b0;
    cmp.ss_at_clamp   <= 1'b0;
    cmp.delay_at_term <= 1'b0;
    tick(12);
    chk({permit, pok, ana.ss_discharge, ana.delay_discharge}, 4'hB);
    cmp.enable <= 1'b1;
    apb(1'b1, 12'h000, 32'h0);
    tick(RST_C + 12);
    chk(ana.ss_discharge, 1'b1);
    apb(1'b1, 12'h000, 32'h3);
    tick(RST_C + 12);
    chk(ana.ss_charge_low, 1'b1);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0000_0013);
    $display("test shutdown done");
    finish_test();
  end
endmodule : crsg_sequencer_tb
